// [design/sdsr_defines.vh]
// Constants for the sigma-delta serial readout block.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef SDSR_DEFINES_VH
`define SDSR_DEFINES_VH

`define SDSR_WORD_W        16
`define SDSR_MAX_REDUCE    3'h6
`define SDSR_EDGES_TOTAL   5'h11
`define SDSR_RESERVED_CODE 16'h8000
`define SDSR_NEG_FULL      16'h8001

`define SDSR_CLK_NS        20
`define SDSR_FILT_NS       50
`define SDSR_FILT_MAX_NS   750
`define SDSR_FILT_CYC      ((`SDSR_FILT_NS + `SDSR_CLK_NS - 1) / `SDSR_CLK_NS)

`define SDSR_ST_IDLE       3'h0
`define SDSR_ST_WINDOW     3'h1
`define SDSR_ST_BUSY       3'h2
`define SDSR_ST_READY      3'h3
`define SDSR_ST_SHIFT      3'h4

`endif

// [design/sdsr_buf2.v]
// Two-entry valid/ready buffer for conversion results.
// Assumes both sides run on clk_in; no combinational path from m_ready_in to s_ready_out.
`timescale 1ns/100ps
module sdsr_buf2 #(
  parameter W = 16
) (
  input  wire         clk_in,      // system clock
  input  wire         rst_in,      // async reset, active high
  input  wire         s_valid_in,  // fill side valid
  output wire         s_ready_out, // fill side ready
  input  wire [W-1:0] s_data_in,   // fill side data
  output wire         m_valid_out, // drain side valid
  input  wire         m_ready_in,  // drain side ready
  output wire [W-1:0] m_data_out   // drain side data
);
  reg [W-1:0] mem_q [0:1];
  reg         wr_q;
  reg         rd_q;
  reg [1:0]   cnt_q;
  wire        push;
  wire        pop;

  assign s_ready_out = (cnt_q != 2'h2);
  assign m_valid_out = (cnt_q != 2'h0);
  assign m_data_out  = mem_q[rd_q];
  assign push        = s_valid_in & s_ready_out;
  assign pop         = m_valid_out & m_ready_in;

  always @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= s_data_in;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

// [design/sdsr_readout.v]
// Two-wire start/readout control of a sigma-delta converter, plus power-fail flag.
// Assumes the modulator core consumes conv_start_out and returns one MSB-aligned
// two's-complement word per start through the result handshake.
// Function
// - After completion and data high, each serial clock fall presents the next bit.
// - Two's-complement word, sign bit first, then MSB down to LSB.
// - Full resolution shifts one sign bit plus exactly 15 magnitude bits.
// - A full cycle uses 17 falling edges; the first starts conversion.
// - Up to six falls inside the reduction window each drop one bit.
// - Falls left after start and reductions shift out the result word.
// - Symmetric range; reserved code 1000...0000 is never produced; code clamps only 16'h8000, so reduced words can be 1000...0.
// - Serial clock pulses under 50ns are rejected; rejection may reach 750ns.
// - Data 1-1-0 across clock high-low-high means a conversion started.
// - Data 0-1-0 across clock high-low-high means a reduction was accepted.
// - Data pattern x00 is ambiguous: data transfer or still converting.
// - Power-fail output active low while sensed input is below reference.
// - Idle lines rest high; a clock fall starts conversion and latches channel.
// - Accepted reduction drives data high until clock rises or window ends.
// - Data low while converting, high on completion, then ready for readout.
// - Channel select 00..11 chooses input one to four.
`timescale 1ns/100ps
`include "sdsr_defines.vh"
module sdsr_readout #(
  parameter WIN_CYC  = 1000, // Reduction window length in clk_in cycles
  parameter FILT_CYC = `SDSR_FILT_CYC
) (
  input  wire        clk_in,            // 50 MHz system clock
  input  wire        rst_in,            // async reset, active high
  input  wire        sclk_in,           // serial clock pin from host
  input  wire        chan_sel_lo_in,    // channel select low bit pin
  input  wire        chan_sel_hi_in,    // channel select high bit pin
  input  wire        fail_sense_in,     // comparator: 1 when sensed input above reference
  output reg         serial_result_out, // serial data line, push-pull
  output wire        fail_flag_n_out,   // open-drain power-fail pin value
  output reg         fail_flag_n_oe_out,// high while pulling fail pin low
  output reg         conv_start_out,    // one-cycle conversion start to core
  output reg  [1:0]  conv_chan_out,     // latched channel to core
  output reg  [2:0]  conv_reduce_out,   // reduction steps taken
  output reg         conv_window_out,   // high while reduction window is open
  input  wire        result_valid_in,   // core result valid
  output wire        result_ready_out,  // core result ready
  input  wire [15:0] result_data_in     // core result, MSB aligned
);
  localparam [2:0] ST_IDLE   = `SDSR_ST_IDLE;
  localparam [2:0] ST_WINDOW = `SDSR_ST_WINDOW;
  localparam [2:0] ST_BUSY   = `SDSR_ST_BUSY;
  localparam [2:0] ST_READY  = `SDSR_ST_READY;
  localparam [2:0] ST_SHIFT  = `SDSR_ST_SHIFT;
  localparam [2:0] MAX_RED   = `SDSR_MAX_REDUCE;
  localparam [4:0] EDGES     = `SDSR_EDGES_TOTAL;
  localparam integer FILT_M1 = FILT_CYC - 1;
  localparam integer WIN_M1  = WIN_CYC - 1;
  localparam [9:0] FILT_LAST = FILT_M1[9:0];
  localparam [15:0] WIN_LAST = WIN_M1[15:0];

  reg        sclk_s1_q;
  reg        sclk_s2_q;
  reg        sel_s1_q;
  reg        sel_s2_q;
  reg        seh_s1_q;
  reg        seh_s2_q;
  reg        fail_s1_q;
  reg        fail_s2_q;
  reg        sclk_filt_q;
  reg [9:0]  filt_cnt_q;
  reg [2:0]  state_q;
  reg [15:0] win_cnt_q;
  reg [15:0] shreg_q;
  reg [4:0]  left_q;
  wire       filt_flip;
  wire       sclk_fall;
  wire       sclk_rise;
  wire       buf_valid;
  wire [15:0] buf_data;
  wire       buf_take;
  wire [15:0] word_clamped;

  // Synchronisers; the first stage feeds only the second
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_s1_q <= 1'b1;
      sclk_s2_q <= 1'b1;
      sel_s1_q  <= 1'b0;
      sel_s2_q  <= 1'b0;
      seh_s1_q  <= 1'b0;
      seh_s2_q  <= 1'b0;
      fail_s1_q <= 1'b1;
      fail_s2_q <= 1'b1;
    end else begin
      sclk_s1_q <= sclk_in;
      sclk_s2_q <= sclk_s1_q;
      sel_s1_q  <= chan_sel_lo_in;
      sel_s2_q  <= sel_s1_q;
      seh_s1_q  <= chan_sel_hi_in;
      seh_s2_q  <= seh_s1_q;
      fail_s1_q <= fail_sense_in;
      fail_s2_q <= fail_s1_q;
    end
  end

  // A level must persist FILT_CYC cycles before it is believed
  assign filt_flip = (sclk_s2_q != sclk_filt_q) && (filt_cnt_q == FILT_LAST);
  assign sclk_fall = filt_flip & sclk_filt_q;
  assign sclk_rise = filt_flip & ~sclk_filt_q;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_filt_q <= 1'b1;
      filt_cnt_q  <= 10'h000;
    end else if (sclk_s2_q == sclk_filt_q) begin
      filt_cnt_q <= 10'h000;
    end else if (filt_flip) begin
      sclk_filt_q <= sclk_s2_q;
      filt_cnt_q  <= 10'h000;
    end else begin
      filt_cnt_q <= filt_cnt_q + 10'h001;
    end
  end

  // Power fail: open drain, pulled low while below reference
  assign fail_flag_n_out = 1'b0;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fail_flag_n_oe_out <= 1'b0;
    end else begin
      fail_flag_n_oe_out <= ~fail_s2_q;
    end
  end

  sdsr_buf2 #(
    .W (`SDSR_WORD_W)
  ) u_buf (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .s_valid_in  (result_valid_in),
    .s_ready_out (result_ready_out),
    .s_data_in   (result_data_in),
    .m_valid_out (buf_valid),
    .m_ready_in  (buf_take),
    .m_data_out  (buf_data)
  );

  // Result is held until the reduction window closes, so resolution is final
  assign buf_take = (state_q == ST_BUSY) & ~conv_window_out;
  assign word_clamped = (buf_data == `SDSR_RESERVED_CODE) ? `SDSR_NEG_FULL : buf_data;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q           <= ST_IDLE;
      serial_result_out <= 1'b1;
      conv_start_out    <= 1'b0;
      conv_chan_out     <= 2'h0;
      conv_reduce_out   <= 3'h0;
      conv_window_out   <= 1'b0;
      win_cnt_q         <= 16'h0000;
      shreg_q           <= 16'h0000;
      left_q            <= 5'h00;
    end else begin
      conv_start_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          serial_result_out <= 1'b1;
          if (sclk_fall) begin
            state_q         <= ST_WINDOW;
            conv_start_out  <= 1'b1;
            conv_chan_out   <= {seh_s2_q, sel_s2_q};
            conv_reduce_out <= 3'h0;
            conv_window_out <= 1'b1;
            win_cnt_q       <= 16'h0000;
          end
        end
        ST_WINDOW: begin
          // Start fall leaves data high; the following rise pulls it low
          if (win_cnt_q == WIN_LAST) begin
            conv_window_out   <= 1'b0;
            serial_result_out <= 1'b0;
            state_q           <= ST_BUSY;
          end else begin
            win_cnt_q <= win_cnt_q + 16'h0001;
            if (sclk_rise) begin
              serial_result_out <= 1'b0;
            end else if (sclk_fall && conv_reduce_out != MAX_RED) begin
              conv_reduce_out   <= conv_reduce_out + 3'h1;
              serial_result_out <= 1'b1;
            end
          end
        end
        ST_BUSY: begin
          // Falls here are ignored; the host sees x00
          serial_result_out <= 1'b0;
          if (buf_valid) begin
            shreg_q           <= word_clamped;
            left_q            <= EDGES - 5'h1 - {2'b00, conv_reduce_out};
            serial_result_out <= 1'b1;
            state_q           <= ST_READY;
          end
        end
        ST_READY, ST_SHIFT: begin
          if (sclk_fall) begin
            if (left_q == 5'h00) begin
              state_q         <= ST_WINDOW;
              // Line goes high so a lost host still reads x-1-0 here, x being the last bit shifted
              serial_result_out <= 1'b1;
              conv_start_out  <= 1'b1;
              conv_chan_out   <= {seh_s2_q, sel_s2_q};
              conv_reduce_out <= 3'h0;
              conv_window_out <= 1'b1;
              win_cnt_q       <= 16'h0000;
            end else begin
              serial_result_out <= shreg_q[15];
              shreg_q           <= {shreg_q[14:0], 1'b0};
              left_q            <= left_q - 5'h01;
              state_q           <= ST_SHIFT;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// [testbench/sdsr_readout_asserts.sv]
// Checker for the serial readout block, bound to its top ports.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/100ps
module sdsr_readout_asserts #(
  parameter WIN_CYC = 1000
) (
  input wire       clk_in,             // system clock
  input wire       rst_in,             // reset
  input wire       chan_sel_lo_in,     // channel pin low
  input wire       chan_sel_hi_in,     // channel pin high
  input wire       fail_sense_in,      // comparator level
  input wire       fail_flag_n_out,    // fail pin value
  input wire       fail_flag_n_oe_out, // fail pin enable
  input wire       conv_start_out,     // start pulse
  input wire [1:0] conv_chan_out,      // latched channel
  input wire [2:0] conv_reduce_out,    // reductions
  input wire       conv_window_out     // window open
);
  reg  [15:0] win_cnt_q;
  wire [15:0] win_cnt_d = conv_window_out ? win_cnt_q + 16'h0001 : 16'h0000;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) win_cnt_q <= 16'h0000;
    else win_cnt_q <= win_cnt_d;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_start_one_cycle: assert property (conv_start_out |=> !conv_start_out)
    else $error("start pulse longer than one cycle");
  a_start_opens_win: assert property (conv_start_out |-> conv_window_out)
    else $error("window not open at start");
  // Pins pass two sync stages before the latch
  a_chan_latched: assert property (conv_start_out |->
    conv_chan_out == $past({chan_sel_hi_in, chan_sel_lo_in}, 3)) else $error("channel not latched at start");
  a_reduce_max: assert property (conv_reduce_out <= 3'h6)
    else $error("reduction count above six");
  a_reduce_step: assert property (conv_window_out ##1 conv_window_out |->
    (conv_reduce_out - $past(conv_reduce_out)) <= 3'h1) else $error("reduction count jumped");
  a_reduce_hold: assert property (!conv_window_out ##1 !conv_window_out |-> $stable(conv_reduce_out))
    else $error("reduction count moved outside window");
  a_window_len: assert property (conv_window_out |-> win_cnt_q < WIN_CYC)
    else $error("window open too long");
  a_fail_drive: assert property (!fail_sense_in [*5] |-> fail_flag_n_oe_out)
    else $error("fail pin not pulled low");
  a_fail_release: assert property (fail_sense_in [*5] |-> !fail_flag_n_oe_out)
    else $error("fail pin not released");
  a_fail_level: assert property (fail_flag_n_out == 1'b0)
    else $error("fail pin value not low");
  c_start: cover property (conv_start_out);
  c_full_reduce: cover property (conv_reduce_out == 3'h6);
  c_fail_release: cover property ($fell(fail_flag_n_oe_out));
endmodule

// [testbench/sdsr_host_model.sv]
// Host model: drives the serial clock, samples data high-low-high.
// Assumes the bench clock; the serial clock rests high between frames.
`timescale 1ns/100ps
module sdsr_host_model (
  input  wire clk_in,   // bench clock
  input  wire data_in,  // serial data from device
  output reg  sclk_out  // serial clock to device
);
  initial sclk_out = 1'b1;
  // Samples at the falling clock, so each phase reads settled data
  task pulse(input integer half, output reg [2:0] pat);
    begin
      @(negedge clk_in) pat[2] = data_in;
      @(posedge clk_in) sclk_out <= 1'b0;
      repeat (half - 1) @(posedge clk_in);
      @(negedge clk_in) pat[1] = data_in;
      @(posedge clk_in) sclk_out <= 1'b1;
      repeat (half - 1) @(posedge clk_in);
      @(negedge clk_in) pat[0] = data_in;
    end
  endtask
  // Low blip shorter than the filter; the device must not count it
  task glitch(input integer width);
    begin
      @(posedge clk_in) sclk_out <= 1'b0;
      repeat (width) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
  endtask
endmodule

// [testbench/tb_sdsr_readout.sv]
// Self-checking bench for the serial readout block.
// Assumes the host model drives the serial clock; the bench plays the core.
`timescale 1ns/100ps
module tb_sdsr_readout;
  localparam WIN = 200;
  reg clk = 1'b0, rst = 1'b1, c_lo = 1'b0, c_hi = 1'b0, sense = 1'b0, r_vld = 1'b0;
  reg [15:0] r_dat = 16'h0000;
  wire sclk, sdata, ready, pf_oe;
  wire [2:0] red;
  integer failures = 0, n_tests = 0, cyc = 0, i, k, r, n;
  reg [15:0] w;
  reg [2:0] p;
  always #10 clk = ~clk;
  sdsr_host_model h (.clk_in(clk), .data_in(sdata), .sclk_out(sclk));
  sdsr_readout #(.WIN_CYC(WIN)) DUT (.clk_in(clk), .rst_in(rst), .sclk_in(sclk),
    .chan_sel_lo_in(c_lo), .chan_sel_hi_in(c_hi), .fail_sense_in(sense),
    .serial_result_out(sdata), .fail_flag_n_out(), .fail_flag_n_oe_out(pf_oe), .conv_start_out(),
    .conv_chan_out(), .conv_reduce_out(red), .conv_window_out(), .result_valid_in(r_vld),
    .result_ready_out(ready), .result_data_in(r_dat));
  task chk(input [2:0] g, input [2:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("MISMATCH at %0t: got %b expected %b", $time, g, e);
      end
    end
  endtask
  // Full-width reserved code 16'h8000 leaves the device as 16'h8001
  function [15:0] expect_word(input [15:0] v);
    expect_word = (v == 16'h8000) ? 16'h8001 : v;
  endfunction
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      finish_test;
    end
  end
  initial begin
    void'($urandom(32'hAD6A));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (i = 0; i < 7; i = i + 1) begin
      r = (i == 0) ? 0 : (i == 1) ? 6 : $urandom_range(5, 1);
      w = (i == 2) ? 16'h8000 : (i == 3) ? 16'h7FFF : $urandom;
      @(posedge clk);
      {c_hi, c_lo} <= $urandom_range(3, 0);
      sense <= $urandom_range(1, 0);
      if (i == 6) begin
        // Host lost its place mid-readout: clock on until a start shows
        n = 0;
        p = 3'h0;
        while (p[1:0] != 2'b10 && n < 40) begin
          h.pulse(7, p);
          n = n + 1;
        end
        chk(p[1:0], 3'h2);
      end else begin
        h.pulse(10, p);
        if (i == 0) chk(p, 3'h6);
        else chk({1'b1, p[1:0]}, 3'h6);
      end
      @(posedge clk);
      r_vld <= 1'b1;
      r_dat <= w;
      do @(posedge clk); while (ready !== 1'b1);
      r_vld <= 1'b0;
      // Ack needs about six clocks, so handshake pulses are slower than readout
      for (k = 0; k < r; k = k + 1) begin
        h.pulse(7, p);
        chk(p, 3'h2);
      end
      if (r == 6) begin
        h.pulse(7, p);
        chk(p, 3'h0);
      end
      n = 0;
      while (sdata !== 1'b1 && n < 2000) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(sdata, 3'h1);
      chk(red, r);
      chk(pf_oe, !sense);
      // Pass 5 stops early so that pass 6 has to hunt for a start
      for (k = 0; k < ((i == 5) ? 5 : 16 - r); k = k + 1) begin
        if (k == 3) h.glitch(2);
        h.pulse(4, p);
        chk(p[0], expect_word(w) >> (15 - k) & 16'h0001);
      end
    end
    finish_test;
  end
endmodule
bind sdsr_readout sdsr_readout_asserts #(.WIN_CYC(WIN_CYC)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .chan_sel_lo_in(chan_sel_lo_in), .chan_sel_hi_in(chan_sel_hi_in), .fail_sense_in(fail_sense_in),
  .fail_flag_n_out(fail_flag_n_out), .fail_flag_n_oe_out(fail_flag_n_oe_out),
  .conv_start_out(conv_start_out), .conv_chan_out(conv_chan_out),
  .conv_reduce_out(conv_reduce_out), .conv_window_out(conv_window_out));
